// >>> src/logic_cell.sv
// One logic cell: table, register with cluster-wide controls, chains.
// Assumes its neighbours feed carry and cascade inputs in the same clock.
`include "logic_cell_map.svh"

module logic_cell (
  // Clock, cluster-wide controls and per-cell load data
  input wire logic clk,
  input wire logic srst,
  input wire logic cen,
  input wire logic ena,
  input wire logic aclr,
  input wire logic apre,
  input wire logic aload,
  input wire logic sclr,
  input wire logic sload,
  input wire logic load_data,
  // Configuration
  input wire logic [1:0] mode,
  input wire logic [`LUT_WIDTH-1:0] lut_cfg,
  input wire logic sel_a,
  input wire logic sel_b,
  input wire logic casc_en,
  // Data inputs
  input wire logic [3:0] data,
  input wire logic carry_in,
  input wire logic casc_in,
  // Results
  output logic out_a,
  output logic out_b,
  output logic carry_out,
  output logic casc_out,
  output logic lut_out,
  output logic reg_out
);

  // ----------------------------------------
  // Table evaluation
  // ----------------------------------------
  function automatic logic half_lut(input logic [`HALF_LUT_WIDTH-1:0] t,
                                    input logic [2:0] idx);
    half_lut = t[idx];
  endfunction : half_lut

  logic reg_q;
  logic reg_d;
  logic [1:0] ops;
  logic sum_bit;
  logic carry_bit;
  logic table_bit;

  always_comb begin
    // Feedback replaces data[1] in counter mode
    ops = (logic_cell_pkg::cell_mode_t'(mode) == logic_cell_pkg::MODE_COUNTER) ?
          {reg_q, data[0]} : {data[1], data[0]};
    sum_bit = half_lut(lut_cfg[`HALF_LUT_WIDTH-1:0], {carry_in, ops});
    carry_bit = half_lut(lut_cfg[`LUT_WIDTH-1:`HALF_LUT_WIDTH],
                         {carry_in, ops});
    table_bit = lut_cfg[data];
    case (logic_cell_pkg::cell_mode_t'(mode))
      logic_cell_pkg::MODE_NORMAL: begin
        lut_out = casc_en ? (table_bit & casc_in) : table_bit;
        carry_out = 1'b0;
      end
      logic_cell_pkg::MODE_ARITH: begin
        lut_out = sum_bit;
        carry_out = carry_bit;
      end
      logic_cell_pkg::MODE_COUNTER: begin
        lut_out = sum_bit;
        carry_out = carry_bit;
      end
      default: begin
        lut_out = table_bit;
        carry_out = 1'b0;
      end
    endcase
    casc_out = lut_out;
  end

  // ----------------------------------------
  // Register
  // ----------------------------------------
  // Asynchronous controls are sampled per clock here: the cell has one clock
  // and a synchronous reset, so "immediate" means next edge, gated by cen only.
  always_comb begin
    reg_d = reg_q;
    if (aclr) begin
      reg_d = 1'b0;
    end else if (apre) begin
      reg_d = 1'b1;
    end else if (aload) begin
      reg_d = load_data;
    end else if (ena) begin
      if (sclr) begin
        reg_d = 1'b0;
      end else if (sload) begin
        reg_d = load_data;
      end else begin
        reg_d = lut_out;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_q <= `REG_RESET;
    end else if (cen) begin
      reg_q <= reg_d;
    end
  end

  // ----------------------------------------
  // Output selection
  // ----------------------------------------
  always_comb begin
    reg_out = reg_q;
    out_a = (sel_a == logic_cell_pkg::OUT_REG) ? reg_q : lut_out;
    out_b = (sel_b == logic_cell_pkg::OUT_REG) ? reg_q : lut_out;
  end

endmodule : logic_cell

// >>> src/logic_cell_map.svh
// Constants for the logic cell and its carry and cascade chains.
// Assumes inclusion by bare name from the package and the cell files.
`ifndef LOGIC_CELL_MAP_SVH
`define LOGIC_CELL_MAP_SVH

// ----------------------------------------
// Cluster geometry
// ----------------------------------------
`define CELLS_PER_CLUSTER 10
`define CLUSTERS_PER_GROUP 4
`define CLUSTER_SKIP 2

// ----------------------------------------
// Table layout and reset values
// ----------------------------------------
`define LUT_WIDTH 16
`define HALF_LUT_WIDTH 8
`define LUT_RESET 16'h0000
`define REG_RESET 1'b0
`define MODE_RESET 2'h0

`endif

// >>> src/logic_cell_pkg.sv
// Types used by the logic cell; its cluster array does not refer to them.
// Assumes logic_cell_map.svh is on the include path.
`include "logic_cell_map.svh"

package logic_cell_pkg;

  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_ARITH = 2'h1,
    MODE_COUNTER = 2'h2,
    MODE_SPARE = 2'h3
  } cell_mode_t;

  // ----------------------------------------
  // Output source select
  // ----------------------------------------
  typedef enum logic {
    OUT_LUT = 1'b0,
    OUT_REG = 1'b1
  } out_sel_t;

endpackage : logic_cell_pkg

// >>> src/cell_cluster_group.sv
// One cluster group of cells with dedicated carry and cascade chains.
// Assumes configuration ports are static from the routing fabric.
`include "logic_cell_map.svh"

module cell_cluster_group (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic CEN,
  // Cluster-wide register controls, one set per cluster
  input wire logic [`CLUSTERS_PER_GROUP-1:0] ENA,
  input wire logic [`CLUSTERS_PER_GROUP-1:0] ACLR,
  input wire logic [`CLUSTERS_PER_GROUP-1:0] APRE,
  input wire logic [`CLUSTERS_PER_GROUP-1:0] ALOAD,
  input wire logic [`CLUSTERS_PER_GROUP-1:0] SCLR,
  input wire logic [`CLUSTERS_PER_GROUP-1:0] SLOAD,
  // Per-cell configuration
  input wire logic [`CLUSTERS_PER_GROUP*`CELLS_PER_CLUSTER*2-1:0] MODE,
  input wire logic [`CLUSTERS_PER_GROUP*`CELLS_PER_CLUSTER*`LUT_WIDTH-1:0] LUT_CFG,
  input wire logic [`CLUSTERS_PER_GROUP*`CELLS_PER_CLUSTER-1:0] SEL_A,
  input wire logic [`CLUSTERS_PER_GROUP*`CELLS_PER_CLUSTER-1:0] SEL_B,
  input wire logic [`CLUSTERS_PER_GROUP*`CELLS_PER_CLUSTER-1:0] CASC_EN,
  // Per-cell data from local routing
  input wire logic [`CLUSTERS_PER_GROUP*`CELLS_PER_CLUSTER*4-1:0] DATA,
  input wire logic [`CLUSTERS_PER_GROUP*`CELLS_PER_CLUSTER-1:0] LOAD_DATA,
  // Chain entries of the even and odd strands
  input wire logic [1:0] CARRY_IN,
  input wire logic [1:0] CASC_IN,
  // Cell outputs to global routing
  output logic [`CLUSTERS_PER_GROUP*`CELLS_PER_CLUSTER-1:0] OUT_A,
  output logic [`CLUSTERS_PER_GROUP*`CELLS_PER_CLUSTER-1:0] OUT_B,
  output logic [1:0] CARRY_OUT,
  output logic [1:0] CASC_OUT
);

  localparam int NCL = `CLUSTERS_PER_GROUP;
  localparam int NCE = `CELLS_PER_CLUSTER;
  localparam int NC = NCL * NCE;

  // ----------------------------------------
  // Chain wiring
  // ----------------------------------------
  // Chain source of a cell: previous cell, or last cell two clusters back.
  // The hop skips the alternate cluster so two strands can fit side by side.
  function automatic int prev_cell(input int k);
    int cl;
    int ce;
    cl = k / NCE;
    ce = k % NCE;
    if (ce != 0) begin
      prev_cell = k - 1;
    end else if (cl >= `CLUSTER_SKIP) begin
      prev_cell = (cl - `CLUSTER_SKIP) * NCE + NCE - 1;
    end else begin
      prev_cell = -1;
    end
  endfunction : prev_cell

  logic [NC-1:0] cin;
  logic [NC-1:0] cout;
  logic [NC-1:0] kin;
  logic [NC-1:0] kout;

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_cell
      localparam int P = prev_cell(g);
      if (P >= 0) begin : g_link
        assign cin[g] = cout[P];
        assign kin[g] = kout[P];
      end else begin : g_head
        assign cin[g] = CARRY_IN[(g / NCE) % 2];
        assign kin[g] = CASC_IN[(g / NCE) % 2];
      end
      logic_cell u_cell (
        .clk(SYS_CLK),
        .srst(SRST),
        .cen(CEN),
        .ena(ENA[g / NCE]),
        .aclr(ACLR[g / NCE]),
        .apre(APRE[g / NCE]),
        .aload(ALOAD[g / NCE]),
        .sclr(SCLR[g / NCE]),
        .sload(SLOAD[g / NCE]),
        .load_data(LOAD_DATA[g]),
        .mode(MODE[2*g +: 2]),
        .lut_cfg(LUT_CFG[`LUT_WIDTH*g +: `LUT_WIDTH]),
        .sel_a(SEL_A[g]),
        .sel_b(SEL_B[g]),
        .casc_en(CASC_EN[g]),
        .data(DATA[4*g +: 4]),
        .carry_in(cin[g]),
        .casc_in(kin[g]),
        .out_a(OUT_A[g]),
        .out_b(OUT_B[g]),
        .carry_out(cout[g]),
        .casc_out(kout[g]),
        .lut_out(),
        .reg_out()
      );
    end
  endgenerate

  // ----------------------------------------
  // Strand exits
  // ----------------------------------------
  // The final carry reaches routing only through a cell output; the
  // strand exits below are for chaining to the next group.
  always_comb begin
    CARRY_OUT[0] = cout[(NCL - 2) * NCE + NCE - 1];
    CARRY_OUT[1] = cout[(NCL - 1) * NCE + NCE - 1];
    CASC_OUT[0] = kout[(NCL - 2) * NCE + NCE - 1];
    CASC_OUT[1] = kout[(NCL - 1) * NCE + NCE - 1];
  end

endmodule : cell_cluster_group

// >>> tb/cell_cluster_group_sva.sv
// Register control checks on the cluster group ports.
// Assumes every select picks the register on OUT_B, and the table on OUT_A in clusters 0 to 2.
module cell_cluster_group_sva (
  // Clock and controls
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic CEN,
  input wire logic [3:0] ENA,
  input wire logic [3:0] ACLR,
  input wire logic [3:0] APRE,
  input wire logic [3:0] ALOAD,
  input wire logic [3:0] SCLR,
  input wire logic [3:0] SLOAD,
  // Cells
  input wire logic [39:0] LOAD_DATA,
  input wire logic [39:0] OUT_A,
  input wire logic [39:0] OUT_B
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Priority of register controls
  // ----------------------------------------
  wire logic [3:0] asy = ACLR | APRE | ALOAD;
  // The reset edge overrides the table, so checks begun on it are skipped
  logic srst_q;
  always_ff @(posedge SYS_CLK) begin
    srst_q <= SRST;
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST || srst_q);
  a_cen_freeze: assert property (!CEN |=> $stable(OUT_B))
    else $error("register moved with enable low");
  a_aclr_wins: assert property (CEN && ACLR[0] |=> OUT_B[9:0] == 10'h0)
    else $error("clear lost");
  a_apre_sets: assert property (CEN && !ACLR[1] && APRE[1] |=> OUT_B[19:10] == 10'h3ff)
    else $error("preset lost");
  a_aload_copy: assert property (CEN && ALOAD[2] && !ACLR[2] && !APRE[2]
    |=> OUT_B[29:20] == $past(LOAD_DATA[29:20])) else $error("load lost");
  a_sclr_first: assert property (CEN && ENA[3] && SCLR[3] && !asy[3]
    |=> OUT_B[39:30] == 10'h0) else $error("sync clear lost");
  a_sload_copy: assert property (CEN && ENA[3] && SLOAD[3] && !SCLR[3] && !asy[3]
    |=> OUT_B[39:30] == $past(LOAD_DATA[39:30])) else $error("sync load lost");
  a_ena_hold: assert property (CEN && !ENA[0] && !asy[0] |=> $stable(OUT_B[9:0]))
    else $error("register moved with cluster enable low");
  a_reg_capture: assert property (CEN && ENA[1] && !asy[1] && !SCLR[1] && !SLOAD[1]
    |=> OUT_B[19:10] == $past(OUT_A[19:10])) else $error("table result not registered");
endmodule : cell_cluster_group_sva

bind cell_cluster_group cell_cluster_group_sva sva (.SYS_CLK(SYS_CLK), .SRST(SRST), .CEN(CEN),
  .ENA(ENA), .ACLR(ACLR), .APRE(APRE), .ALOAD(ALOAD), .SCLR(SCLR), .SLOAD(SLOAD),
  .LOAD_DATA(LOAD_DATA), .OUT_A(OUT_A), .OUT_B(OUT_B));

// >>> tb/chain_neighbour.sv
// Neighbouring cells that feed the carry and cascade entries of both strands.
// Assumes the bench picks the levels; they land one edge later, unlike a real cell, whose chain outputs are combinational.
module chain_neighbour (
  // Clock and requested levels
  input wire logic clk,
  input wire logic [1:0] carry_set,
  input wire logic [1:0] casc_set,
  // Chain entries
  output logic [1:0] carry_in,
  output logic [1:0] casc_in
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk) begin
    carry_in <= carry_set;
    casc_in <= casc_set;
  end
endmodule : chain_neighbour

// >>> tb/cell_cluster_group_tb.sv
// Bench for one cluster group: adds, cascades, control steps and a counter.
// Assumes the chain neighbour model feeds both strand entries.
module cell_cluster_group_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, cen;
  logic [3:0] ena, aclr, apre, aload, sclr, sload;
  logic [79:0] mode;
  logic [639:0] lut;
  logic [39:0] sel_a, sel_b, casc_en, ld, out_a, out_b;
  logic [159:0] data;
  logic [1:0] cy_set, cs_set, cy_in, cs_in, cy_out, cs_out;
  logic [16:0] st [7];
  int fail_count = 0, comparisons = 0, cycles = 0;
  cell_cluster_group dut (.SYS_CLK(clk), .SRST(srst), .CEN(cen), .ENA(ena), .ACLR(aclr),
    .APRE(apre), .ALOAD(aload), .SCLR(sclr), .SLOAD(sload), .MODE(mode), .LUT_CFG(lut),
    .SEL_A(sel_a), .SEL_B(sel_b), .CASC_EN(casc_en), .DATA(data), .LOAD_DATA(ld),
    .CARRY_IN(cy_in), .CASC_IN(cs_in), .OUT_A(out_a), .OUT_B(out_b), .CARRY_OUT(cy_out),
    .CASC_OUT(cs_out));
  chain_neighbour nb (.clk(clk), .carry_set(cy_set), .casc_set(cs_set), .carry_in(cy_in),
    .casc_in(cs_in));
  // ----------------------------------------
  // Tasks and run
  // ----------------------------------------
  task chk(input string what, input logic [39:0] want, input logic [39:0] got);
    comparisons++;
    if (got !== want) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, want, got);
    end
  endtask : chk
  task print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  task wait_n(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : wait_n
  // Carry lands one edge after the operands, so results are read two edges on
  task add(input logic [19:0] a, input logic [19:0] b, input logic cin);
    logic [20:0] s;
    logic [39:0] w;
    s = {1'b0, a} + {1'b0, b} + {20'h0, cin};
    w = {10'h0, s[19:10], 10'h0, s[9:0]};
    @(posedge clk);
    for (int j = 0; j < 20; j++) begin
      data[4 * (j < 10 ? j : j + 10) +: 2] <= {b[j], a[j]};
    end
    cy_set[0] <= cin;
    wait_n(2);
    chk("sum", w, out_a & 40'h003ff003ff);
    chk("held sum", w, out_b & 40'h003ff003ff);
    chk("carry exit", {39'h0, s[20]}, {39'h0, cy_out[0]});
    chk("cascade strand 0", {39'h0, s[19]}, {39'h0, cs_out[0]});
  endtask : add
  initial begin
    clk = 1'b0;
    forever begin
      #5 clk = ~clk;
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    {srst, cen, ena, aclr, apre, aload, sclr, sload} = {2'h3, 4'hf, 20'h0};
    mode = {20'h0, 20'h55555, 20'h0, 20'h55555};
    lut = {{10{16'h8000}}, {10{16'he896}}, {10{16'h8000}}, {10{16'he896}}};
    sel_a = 40'hffc0000000;
    sel_b = 40'hffffffffff;
    casc_en = 40'hffffffffff;
    ld = 40'h5a5a5a56b5;
    data = {40'hffffffffff, 40'h0, 40'hffffffffff, 40'h0};
    cy_set = 2'h0;
    cs_set = 2'h3;
    st = '{{7'h64, 10'h2b5}, {7'h63, 10'h0}, {7'h61, 10'h2b5}, {7'h42, 10'h2b5},
      {7'h30, 10'h2b5}, {7'h6c, 10'h3ff}, {7'h78, 10'h0}};
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    add(20'hfffff, 20'h00000, 1'b1);
    add(20'h003ff, 20'h00001, 1'b0);
    add(20'h7ffff, 20'h00000, 1'b1);
    add(20'h12345, 20'h0abcd, 1'b0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      cs_set[1] <= (i != 1);
      data[60] <= (i != 2);
      wait_n(2);
      chk("cascade exit", {39'h0, i == 0}, {39'h0, cs_out[1]});
      chk("normal carry", 40'h0, {39'h0, cy_out[1]});
      chk("register on a", {30'h0, i == 0 ? 10'h3ff : 10'h0}, {30'h0, out_a[39:30]});
    end
    foreach (st[i]) begin
      @(posedge clk);
      cen <= st[i][16];
      ena <= {4{st[i][15]}};
      aclr <= {4{st[i][14]}};
      apre <= {4{st[i][13]}};
      aload <= {4{st[i][12]}};
      sclr <= {4{st[i][11]}};
      sload <= {4{st[i][10]}};
      wait_n(1);
      chk("cluster register", {30'h0, st[i][9:0]}, {30'h0, out_b[9:0]});
    end
    @(posedge clk);
    {aclr, apre, aload, sload} <= 16'h0;
    mode <= {20'h0, 20'haaaaa, 20'h0, 20'haaaaa};
    data[39:0] <= 40'h1;
    data[119:80] <= 40'h0;
    sclr <= 4'hf;
    @(posedge clk);
    sclr <= 4'h0;
    wait_n(5);
    chk("counter", 40'h5, out_b & 40'h003ff003ff);
    print_verdict();
  end
endmodule : cell_cluster_group_tb
